// [core/sipo_defines.svh]
`ifndef SIPO_DEFINES_SVH
`define SIPO_DEFINES_SVH
`define SIPO_WIDTH      8
`define SIPO_FIFO_DEPTH 32
`define SIPO_RESET_VAL  8'h00
`define SIPO_ARM_CYCLES 3'h5
`endif

// [core/sipo_pkg.sv]
package sipo_pkg;
    typedef logic [7:0] sipo_byte_t;
    typedef logic [2:0] sipo_sync_t;
endpackage : sipo_pkg

// [core/sipo_fifo_if.sv]
`timescale 1ns/1ns
interface sipo_fifo_if;
    logic                 in_valid;
    logic                 in_ready;
    sipo_pkg::sipo_byte_t in_data;
    logic                 out_valid;
    logic                 out_ready;
    sipo_pkg::sipo_byte_t out_data;
    modport fill  (output in_valid, input in_ready, output in_data);
    modport store (input in_valid, output in_ready, input in_data);
    modport drain (input out_valid, output out_ready, input out_data);
    modport src   (output out_valid, input out_ready, output out_data);
endinterface : sipo_fifo_if

// [core/sipo_fifo.sv]
`timescale 1ns/1ns
`include "sipo_defines.svh"
module sipo_fifo #(
    parameter int WIDTH = `SIPO_WIDTH,
    parameter int DEPTH = `SIPO_FIFO_DEPTH
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_ff != DEPTH[AW:0]);
    assign out_valid = (cnt_ff != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ff];

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else if (flush) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : sipo_fifo

// [core/sipo_top.sv]
`timescale 1ns/1ns
`include "sipo_defines.svh"
module sipo_top (
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic serial_data_in,
    input  wire logic shift_clock,
    input  wire logic storage_clock,
    input  wire logic shift_clear_n,
    input  wire logic storage_clear_n,
    output logic      cascade_out,
    output logic      parallel_out_first,
    output logic      parallel_out_b,
    output logic      parallel_out_c,
    output logic      parallel_out_d,
    output logic      parallel_out_e,
    output logic      parallel_out_f,
    output logic      parallel_out_g,
    output logic      parallel_out_last,
    output logic      overrun
);
    // ==========================================
    // reset release
    logic [1:0] rst_sync_ff;
    logic       rst_n;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ==========================================
    // pin synchronisers
    sipo_pkg::sipo_sync_t sd_ff;
    sipo_pkg::sipo_sync_t sck_ff;
    sipo_pkg::sipo_sync_t stck_ff;
    sipo_pkg::sipo_sync_t sclr_ff;
    sipo_pkg::sipo_sync_t tclr_ff;
    logic                 sd_q_ff;
    logic                 sck_q_ff;
    logic                 stck_q_ff;
    logic                 sclr_q_ff;
    logic                 tclr_q_ff;

    // settled level: second and third stages agree
    function automatic logic settle(input sipo_pkg::sipo_sync_t s, input logic prev);
        settle = (s[1] == s[2]) ? s[2] : prev;
    endfunction : settle

    // serial data pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sd_ff <= 3'h0;
        end else begin
            sd_ff <= {sd_ff[1:0], serial_data_in};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sd_q_ff <= 1'b0;
        end else begin
            sd_q_ff <= settle(sd_ff, sd_q_ff);
        end
    end

    // shift clock pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_ff <= 3'h0;
        end else begin
            sck_ff <= {sck_ff[1:0], shift_clock};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_q_ff <= 1'b0;
        end else begin
            sck_q_ff <= settle(sck_ff, sck_q_ff);
        end
    end

    // storage clock pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stck_ff <= 3'h0;
        end else begin
            stck_ff <= {stck_ff[1:0], storage_clock};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stck_q_ff <= 1'b0;
        end else begin
            stck_q_ff <= settle(stck_ff, stck_q_ff);
        end
    end

    // shift clear pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclr_ff <= 3'h0;
        end else begin
            sclr_ff <= {sclr_ff[1:0], shift_clear_n};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sclr_q_ff <= 1'b0;
        end else begin
            sclr_q_ff <= settle(sclr_ff, sclr_q_ff);
        end
    end

    // storage clear pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tclr_ff <= 3'h0;
        end else begin
            tclr_ff <= {tclr_ff[1:0], storage_clear_n};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tclr_q_ff <= 1'b0;
        end else begin
            tclr_q_ff <= settle(tclr_ff, tclr_q_ff);
        end
    end

    // ==========================================
    // edge detection
    logic       sck_prev_ff;
    logic       stck_prev_ff;
    logic       shift_rise;
    logic       store_rise;

    // rising edge of a settled pin level
    function automatic logic rise(input logic now_lvl, input logic prev_lvl);
        rise = now_lvl && !prev_lvl;
    endfunction : rise

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sck_prev_ff <= 1'b0;
        end else begin
            sck_prev_ff <= sck_q_ff;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stck_prev_ff <= 1'b0;
        end else begin
            stck_prev_ff <= stck_q_ff;
        end
    end

    // ==========================================
    // edge arming
    logic [2:0] arm_cnt_ff;
    logic       armed;

    // a pin already high at reset release is not an edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arm_cnt_ff <= 3'h0;
        end else if (!armed) begin
            arm_cnt_ff <= arm_cnt_ff + 3'h1;
        end
    end
    assign armed = (arm_cnt_ff == `SIPO_ARM_CYCLES);

    assign shift_rise = armed && rise(sck_q_ff, sck_prev_ff);
    assign store_rise = armed && rise(stck_q_ff, stck_prev_ff);

    // ==========================================
    // shift register
    sipo_pkg::sipo_byte_t shift_ff;
    sipo_pkg::sipo_byte_t nxt_shift;

    always_comb begin
        nxt_shift = {shift_ff[6:0], sd_q_ff};
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            shift_ff <= `SIPO_RESET_VAL;
        end else if (!sclr_q_ff) begin
            shift_ff <= `SIPO_RESET_VAL;
        end else if (shift_rise) begin
            shift_ff <= nxt_shift;
        end
    end

    assign cascade_out = shift_ff[7];

    // ==========================================
    // snapshot buffer toward storage
    sipo_fifo_if          fq ();
    logic                 pend_valid_ff;
    sipo_pkg::sipo_byte_t pend_data_ff;

    // snapshot taken before a simultaneous shift, so storage lags by one pulse
    // an edge seen while the storage clear is low must not land after release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_valid_ff <= 1'b0;
        end else if (!tclr_q_ff) begin
            pend_valid_ff <= 1'b0;
        end else if (store_rise) begin
            pend_valid_ff <= 1'b1;
        end else if (fq.in_ready) begin
            pend_valid_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend_data_ff <= `SIPO_RESET_VAL;
        end else if (store_rise) begin
            pend_data_ff <= (!sclr_q_ff) ? `SIPO_RESET_VAL : shift_ff;
        end
    end

    // ==========================================
    // snapshot fifo
    logic store_flush;

    // a storage clear also drops snapshots still in flight
    assign store_flush  = !tclr_q_ff;
    assign fq.in_valid  = pend_valid_ff;
    assign fq.in_data   = pend_data_ff;
    assign fq.out_ready = 1'b1;

    sipo_fifo #(
        .WIDTH(`SIPO_WIDTH),
        .DEPTH(`SIPO_FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .flush     (store_flush),
        .in_valid  (fq.in_valid),
        .in_ready  (fq.in_ready),
        .in_data   (fq.in_data),
        .out_valid (fq.out_valid),
        .out_ready (fq.out_ready),
        .out_data  (fq.out_data)
    );

    // ==========================================
    // overrun status
    // not expected: the fifo drains every cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            overrun <= 1'b0;
        end else begin
            overrun <= store_rise && pend_valid_ff && !fq.in_ready;
        end
    end

    // ==========================================
    // storage register
    sipo_pkg::sipo_byte_t store_ff;

    // clear wins over a pending load
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            store_ff <= `SIPO_RESET_VAL;
        end else if (!tclr_q_ff) begin
            store_ff <= `SIPO_RESET_VAL;
        end else if (fq.out_valid) begin
            store_ff <= fq.out_data;
        end
    end

    // ==========================================
    // parallel outputs, first stage to first output
    assign parallel_out_first = store_ff[0];
    assign parallel_out_b     = store_ff[1];
    assign parallel_out_c     = store_ff[2];
    assign parallel_out_d     = store_ff[3];
    assign parallel_out_e     = store_ff[4];
    assign parallel_out_f     = store_ff[5];
    assign parallel_out_g     = store_ff[6];
    assign parallel_out_last  = store_ff[7];
endmodule : sipo_top

// [sim/sipo_top_asserts.sv]
`timescale 1ns/1ns
module sipo_top_asserts (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic serial_data_in,
    input wire logic shift_clock,
    input wire logic storage_clock,
    input wire logic shift_clear_n,
    input wire logic storage_clear_n,
    input wire logic cascade_out,
    input wire logic parallel_out_first,
    input wire logic parallel_out_b,
    input wire logic parallel_out_c,
    input wire logic parallel_out_d,
    input wire logic parallel_out_e,
    input wire logic parallel_out_f,
    input wire logic parallel_out_g,
    input wire logic parallel_out_last,
    input wire logic overrun
);
    wire logic [7:0] outs;
    assign outs = {parallel_out_last, parallel_out_g, parallel_out_f, parallel_out_e,
                   parallel_out_d, parallel_out_c, parallel_out_b, parallel_out_first};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    // =====
    // clears, reset, status
    a_shift_clr_zero: assert property ((!shift_clear_n)[*6] |-> !cascade_out)
        else $error("cascade not cleared");
    a_store_clr_zero: assert property ((!storage_clear_n)[*8] |-> outs == 8'h00)
        else $error("outputs not cleared");
    a_store_clr_fast: assert property ($fell(storage_clear_n) |-> ##[1:6] outs == 8'h00)
        else $error("storage clear too slow");
    a_reset_outs_zero: assert property ($rose(reset_n) |-> ##1 outs == 8'h00)
        else $error("outputs set after reset");
    a_no_overrun: assert property (!overrun)
        else $error("snapshot lost");
    // =====
    // clock edges, clear covers
    a_cascade_hold: assert property ((!shift_clock && shift_clear_n)[*8] |-> $stable(cascade_out))
        else $error("cascade moved without edge");
    a_outs_hold: assert property ((!storage_clock && storage_clear_n)[*8] ##1 !storage_clock |-> $stable(outs))
        else $error("outputs moved without edge");
    a_last_snapshot: assert property ($rose(storage_clock) && shift_clear_n && storage_clear_n ##1 (shift_clear_n && storage_clear_n)[*8] |-> parallel_out_last == $past(cascade_out, 8))
        else $error("last output not old last stage");
    c_tied: cover property ($rose(storage_clock) && $rose(shift_clock));
    c_shift_clr: cover property ($fell(shift_clear_n));
    c_store_clr: cover property ($fell(storage_clear_n));
endmodule : sipo_top_asserts
bind sipo_top sipo_top_asserts u_asserts (.clock(clock), .reset_n(reset_n),
    .serial_data_in(serial_data_in), .shift_clock(shift_clock), .storage_clock(storage_clock),
    .shift_clear_n(shift_clear_n), .storage_clear_n(storage_clear_n), .cascade_out(cascade_out),
    .parallel_out_first(parallel_out_first), .parallel_out_b(parallel_out_b),
    .parallel_out_c(parallel_out_c), .parallel_out_d(parallel_out_d),
    .parallel_out_e(parallel_out_e), .parallel_out_f(parallel_out_f),
    .parallel_out_g(parallel_out_g), .parallel_out_last(parallel_out_last), .overrun(overrun));

// [sim/sipo_mcu_model.sv]
`timescale 1ns/1ns
module sipo_mcu_model (
    input  wire logic clock,
    output logic      serial_data_in,
    output logic      shift_clock,
    output logic      storage_clock,
    output logic      shift_clear_n,
    output logic      storage_clear_n
);
    initial begin
        {serial_data_in, shift_clock, storage_clock} = 3'h0;
        {shift_clear_n, storage_clear_n} = 2'h3;
    end
    // =====
    // one pulse on either or both clock pins
    task automatic pulse(input logic do_sh, input logic do_st, input logic bit_val, input int gap);
        @(posedge clock);
        serial_data_in <= bit_val;
        repeat (gap) @(posedge clock);
        shift_clock <= do_sh;
        storage_clock <= do_st;
        repeat (gap) @(posedge clock);
        shift_clock <= 1'b0;
        storage_clock <= 1'b0;
        serial_data_in <= ~bit_val;
        repeat (gap) @(posedge clock);
    endtask : pulse
    task automatic clears(input logic sh_n, input logic st_n);
        @(posedge clock);
        shift_clear_n <= sh_n;
        storage_clear_n <= st_n;
        repeat (8) @(posedge clock);
    endtask : clears
endmodule : sipo_mcu_model

// [sim/test_sipo_top.sv]
`timescale 1ns/1ns
module test_sipo_top;
    logic       clock = 1'b0;
    logic       reset_n = 1'b0;
    wire        sdi, sck, stk, shc_n, stc_n;
    wire  [7:0] outs;
    logic       cas;
    logic       ovr;
    int         ovr_cnt = 0;
    int         err_total = 0;
    int         tests_run = 0;
    int         m_sh = 0;
    int         m_st = 0;
    int         b;
    sipo_mcu_model u_mcu (.clock(clock), .serial_data_in(sdi), .shift_clock(sck),
        .storage_clock(stk), .shift_clear_n(shc_n), .storage_clear_n(stc_n));
    sipo_top u_dut (.clock(clock), .reset_n(reset_n), .serial_data_in(sdi), .shift_clock(sck),
        .storage_clock(stk), .shift_clear_n(shc_n), .storage_clear_n(stc_n), .cascade_out(cas),
        .parallel_out_first(outs[0]), .parallel_out_b(outs[1]), .parallel_out_c(outs[2]),
        .parallel_out_d(outs[3]), .parallel_out_e(outs[4]), .parallel_out_f(outs[5]),
        .parallel_out_g(outs[6]), .parallel_out_last(outs[7]), .overrun(ovr));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic finish_test();
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    task automatic chk_cas(input logic exp);
        tests_run++;
        if (cas !== exp) begin
            err_total++;
            $display("[FAIL] %0t cascade %b exp %b", $time, cas, exp);
        end
    endtask : chk_cas
    task automatic chk_outs(input logic [7:0] exp);
        tests_run++;
        if (outs !== exp) begin
            err_total++;
            $display("[FAIL] %0t outputs %h exp %h", $time, outs, exp);
        end
    endtask : chk_outs
    task automatic chk_ovr(input int exp);
        tests_run++;
        if (ovr_cnt != exp) begin
            err_total++;
            $display("[FAIL] %0t overrun pulses %0d exp %0d", $time, ovr_cnt, exp);
        end
    endtask : chk_ovr
    // overrun is a one-cycle pulse: count every cycle
    always @(posedge clock) begin
        if (reset_n && ovr !== 1'b0) begin
            ovr_cnt++;
        end
    end
    // =====
    // shift, store, tied clocks, clears
    initial begin
        void'($urandom(32'hCA2714F2));
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        repeat (8) @(posedge clock);
        chk_outs(8'h00);
        for (int i = 0; i < 24; i++) begin
            b = $urandom_range(1, 0);
            u_mcu.pulse(1'b1, 1'b0, b[0], 5 + $urandom_range(3, 0));
            m_sh = ((m_sh << 1) | b) & 8'hFF;
            chk_cas(m_sh[7]);
            if (i % 8 == 7) begin
                u_mcu.pulse(1'b0, 1'b1, 1'b0, 5);
                m_st = m_sh;
                chk_outs(8'(m_st));
            end
        end
        for (int i = 0; i < 10; i++) begin
            b = $urandom_range(1, 0);
            u_mcu.pulse(1'b1, 1'b1, b[0], 5 + $urandom_range(3, 0));
            m_st = m_sh;
            m_sh = ((m_sh << 1) | b) & 8'hFF;
            chk_outs(8'(m_st));
            chk_cas(m_sh[7]);
        end
        u_mcu.clears(1'b0, 1'b1);
        u_mcu.pulse(1'b1, 1'b0, 1'b1, 6);
        chk_cas(1'b0);
        u_mcu.clears(1'b1, 1'b1);
        m_sh = 0;
        u_mcu.pulse(1'b0, 1'b1, 1'b0, 6);
        chk_outs(8'h00);
        for (int i = 0; i < 8; i++) begin
            b = $urandom_range(1, 0);
            u_mcu.pulse(1'b1, 1'b0, b[0], 5);
            m_sh = ((m_sh << 1) | b) & 8'hFF;
            chk_cas(m_sh[7]);
        end
        u_mcu.pulse(1'b0, 1'b1, 1'b0, 5);
        m_st = m_sh;
        chk_outs(8'(m_st));
        u_mcu.clears(1'b1, 1'b0);
        m_st = 0;
        chk_outs(8'(m_st));
        u_mcu.pulse(1'b0, 1'b1, 1'b0, 6);
        chk_outs(8'(m_st));
        chk_cas(m_sh[7]);
        u_mcu.clears(1'b1, 1'b1);
        u_mcu.pulse(1'b0, 1'b1, 1'b0, 6);
        m_st = m_sh;
        chk_outs(8'(m_st));
        chk_ovr(0);
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge clock);
        err_total++;
        finish_test();
    end
endmodule : test_sipo_top
